/* File: rtl/csi2_cfg_pkg.sv */
/*
 * Shared constants and carrier types for the CSI-2 output configuration bank.
 * Assumes a 32-bit Avalon-MM slave with byte addressing; each 8-bit register
 * sits in the low lane of one aligned word at four times its index.
 */
package csi2_cfg_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_PORT0 = 6'h13;
    localparam logic [IDX_W-1:0] IDX_PORT1 = 6'h14;
    localparam logic [IDX_W-1:0] IDX_ROUTE = 6'h16;
    localparam logic [IDX_W-1:0] IDX_VC = 6'h2E;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h30;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h31;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PORT0 = 8'h3F;
    localparam logic [7:0] RST_PORT1 = 8'h00;
    localparam logic [7:0] RST_ROUTE = 8'h02;
    localparam logic [7:0] RST_VC = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int EN_W = 6;
    localparam logic [EN_W-1:0] EN_ALL = 6'h3F;
    localparam logic [EN_W-1:0] EN_NONE = 6'h00;
    localparam int ROUTE_GP3_BIT = 2;
    localparam int ROUTE_GP0_BIT = 1;
    localparam int STATUS_BIT = 0;
    localparam int VC_LSB = 6;
    localparam int VC_W = 2;
    localparam int IRQ_W = 2;
    localparam int IRQ_RISE_BIT = 0;
    localparam int IRQ_FALL_BIT = 1;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic waitrequest;
    } avmm_rsp_t;

    typedef enum logic [0:0] {
        HS_WAIT = 1'b0,
        HS_ACK = 1'b1
    } hs_state_t;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] byteAddr(input logic [IDX_W-1:0] idx);
        byteAddr = {idx, 2'b00};
    endfunction

endpackage

/* File: rtl/avmm_handshake.sv */
/*
 * Avalon-MM waitrequest handshake: every access waits exactly one cycle.
 * Assumes the master holds its request until it sees waitrequest low.
 */
module avmm_handshake
    import csi2_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire avmm_req_t req,
    input wire logic [DATA_W-1:0] rdataIn,
    output avmm_rsp_t rsp,
    output logic accept
);

    hs_state_t state_q, state_d;
    avmm_rsp_t rsp_q, rsp_d;

    // ------------------------------------------------------------
    // Next state: wait one cycle, then release waitrequest
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        rsp_d = rsp_q;
        case (state_q)
            HS_WAIT: begin
                if (req.read || req.write) begin
                    state_d = HS_ACK;
                    rsp_d.waitrequest = 1'b0;
                    rsp_d.readdata = req.read ? rdataIn : rsp_q.readdata;
                end
            end
            HS_ACK: begin
                state_d = HS_WAIT;
                rsp_d.waitrequest = 1'b1;
            end
            default: begin
                state_d = HS_WAIT;
                rsp_d.waitrequest = 1'b1;
            end
        endcase
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HS_WAIT;
            rsp_q <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
        end else if (clkEn) begin
            state_q <= state_d;
            rsp_q <= rsp_d;
        end
    end

    assign rsp = rsp_q;
    assign accept = clkEn && (state_q == HS_ACK) && (req.read || req.write); // Completing edge

    chk_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clkEn && state_q == HS_WAIT && (req.read || req.write)) |=> !rsp_q.waitrequest)
        else $error("waitrequest not released after one wait cycle");

endmodule // avmm_handshake

/* File: rtl/irq_sticky.sv */
/*
 * Sticky event status with write-one-to-clear, a mask of the same layout and
 * one level interrupt. Assumes write strobes are single-cycle accepts.
 */
module irq_sticky
    import csi2_cfg_pkg::*;
#(
    parameter int W = IRQ_W
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [W-1:0] events,
    input wire logic clrWe,
    input wire logic maskWe,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);

    logic [W-1:0] status_q, status_d, mask_q, mask_d;
    logic irq_q, irq_d;

    // Set wins over a clear landing in the same cycle
    always_comb begin
        status_d = (status_q & ~(clrWe ? wdata : '0)) | events;
        mask_d = maskWe ? wdata : mask_q;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else if (clkEn) begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = irq_q;

    chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_q == |(status_q & mask_q))
        else $error("interrupt level does not match masked status");

endmodule // irq_sticky

/* File: rtl/csi2_output_config.sv */
/*
 * CSI-2 output configuration bank: port enables, virtual channel select and
 * link-good routing to two general-purpose pins, with a link-good status bit
 * and interrupts on its edges. Assumes a synchronous link-good input and an
 * Avalon-MM master that waits on waitrequest.
 */

// Functional notes
// - Port zero has a six-bit enable field, reset all ones, where all zeros disables and all ones enables.
// - Port one has a six-bit enable field, reset zero, where all ones enables and all zeros disables.
// - Routing bit 2, reset low, drives the link-good level out on general-purpose pin 3 when high.
// - Routing bit 1, reset high, drives the link-good level out on general-purpose pin 0 when high.
// - Bit 0 of the routing register reads the captured link-good level and resets to zero.
// - Bits 7-6 of the channel register pick virtual channel zero to three for output packets, reset zero.
module csi2_output_config
    import csi2_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire avmm_req_t avmmReq,
    output avmm_rsp_t avmmRsp,
    input wire logic linkGood,
    output logic [EN_W-1:0] portZeroEnable,
    output logic [EN_W-1:0] portOneEnable,
    output logic [VC_W-1:0] virtualChannel,
    output logic gpioZeroOut,
    output logic gpioZeroOe,
    output logic gpioThreeOut,
    output logic gpioThreeOe,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic accept;
    logic acceptWr;
    logic lane0;
    logic [DATA_W-1:0] rdata;
    logic wrPort0, wrPort1, wrRoute, wrVc, wrIrqClr, wrIrqMask;
    logic [7:0] port0_q, port0_d;
    logic [7:0] port1_q, port1_d;
    logic [7:1] route_q, route_d;
    logic [7:0] vc_q, vc_d;
    logic linkGood_q, linkGood_d;
    logic gp0Out_q, gp0Out_d, gp0Oe_q, gp0Oe_d;
    logic gp3Out_q, gp3Out_d, gp3Oe_q, gp3Oe_d;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irqStatus, irqMask;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    avmm_handshake u_hs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .req(avmmReq),
        .rdataIn(rdata),
        .rsp(avmmRsp),
        .accept(accept)
    );

    // Write decode; unmapped offsets are left untouched
    assign acceptWr = accept && avmmReq.write;
    assign lane0 = avmmReq.byteenable[0];
    assign wrPort0 = acceptWr && lane0 && (avmmReq.address == byteAddr(IDX_PORT0));
    assign wrPort1 = acceptWr && lane0 && (avmmReq.address == byteAddr(IDX_PORT1));
    assign wrRoute = acceptWr && lane0 && (avmmReq.address == byteAddr(IDX_ROUTE));
    assign wrVc = acceptWr && lane0 && (avmmReq.address == byteAddr(IDX_VC));
    assign wrIrqClr = acceptWr && lane0 && (avmmReq.address == byteAddr(IDX_IRQ_STAT));
    assign wrIrqMask = acceptWr && lane0 && (avmmReq.address == byteAddr(IDX_IRQ_MASK));

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------

    // Next values of the four configuration registers
    always_comb begin
        port0_d = port0_q;
        port1_d = port1_q;
        route_d = route_q;
        vc_d = vc_q;
        if (wrPort0) begin
            port0_d = avmmReq.writedata[7:0];
        end
        if (wrPort1) begin
            port1_d = avmmReq.writedata[7:0];
        end
        if (wrRoute) begin
            route_d = avmmReq.writedata[7:1];
        end
        if (wrVc) begin
            vc_d = avmmReq.writedata[7:0];
        end
    end

    // Configuration registers, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port0_q <= RST_PORT0;
            port1_q <= RST_PORT1;
            route_q <= RST_ROUTE[7:1];
            vc_q <= RST_VC;
        end else if (clkEn) begin
            port0_q <= port0_d;
            port1_q <= port1_d;
            route_q <= route_d;
            vc_q <= vc_d;
        end
    end

    // Output fields come straight from the stored registers
    assign portZeroEnable = port0_q[EN_W-1:0];
    assign portOneEnable = port1_q[EN_W-1:0];
    assign virtualChannel = vc_q[VC_LSB+VC_W-1:VC_LSB];

    // ------------------------------------------------------------
    // Link-good capture and pin routing
    // ------------------------------------------------------------

    // Pins follow the routing bits and the captured link-good level
    always_comb begin
        linkGood_d = linkGood;
        gp0Oe_d = route_q[ROUTE_GP0_BIT];
        gp0Out_d = route_q[ROUTE_GP0_BIT] && linkGood_q;
        gp3Oe_d = route_q[ROUTE_GP3_BIT];
        gp3Out_d = route_q[ROUTE_GP3_BIT] && linkGood_q;
    end

    // Link capture and pin flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            linkGood_q <= 1'b0;
            gp0Oe_q <= 1'b0;
            gp0Out_q <= 1'b0;
            gp3Oe_q <= 1'b0;
            gp3Out_q <= 1'b0;
        end else if (clkEn) begin
            linkGood_q <= linkGood_d;
            gp0Oe_q <= gp0Oe_d;
            gp0Out_q <= gp0Out_d;
            gp3Oe_q <= gp3Oe_d;
            gp3Out_q <= gp3Out_d;
        end
    end

    // Pin drivers come straight from flops
    assign gpioZeroOut = gp0Out_q;
    assign gpioZeroOe = gp0Oe_q;
    assign gpioThreeOut = gp3Out_q;
    assign gpioThreeOe = gp3Oe_q;

    // ------------------------------------------------------------
    // Interrupts on link-good edges
    // ------------------------------------------------------------
    // Edge detector; the capture flop resets low like the idle input
    assign events[IRQ_RISE_BIT] = linkGood && !linkGood_q;
    assign events[IRQ_FALL_BIT] = !linkGood && linkGood_q;

    // Sticky status, mask and level interrupt
    irq_sticky #(
        .W(IRQ_W)
    ) u_irq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .events(events),
        .clrWe(wrIrqClr),
        .maskWe(wrIrqMask),
        .wdata(avmmReq.writedata[IRQ_W-1:0]),
        .status(irqStatus),
        .mask(irqMask),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------

    // Narrow registers sit in the low lane; unmapped words read as zero
    always_comb begin
        rdata = UNMAPPED_RDATA;
        if (avmmReq.address == byteAddr(IDX_PORT0)) begin
            rdata[7:0] = port0_q;
        end else if (avmmReq.address == byteAddr(IDX_PORT1)) begin
            rdata[7:0] = port1_q;
        end else if (avmmReq.address == byteAddr(IDX_ROUTE)) begin
            rdata[7:0] = {route_q, linkGood_q};
        end else if (avmmReq.address == byteAddr(IDX_VC)) begin
            rdata[7:0] = vc_q;
        end else if (avmmReq.address == byteAddr(IDX_IRQ_STAT)) begin
            rdata[IRQ_W-1:0] = irqStatus;
        end else if (avmmReq.address == byteAddr(IDX_IRQ_MASK)) begin
            rdata[IRQ_W-1:0] = irqMask;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_enable_reset_vals: assert property ($rose(rst_n) |->
        portZeroEnable == EN_ALL && portOneEnable == EN_NONE && virtualChannel == 2'b00)
        else $error("enable or channel fields wrong after reset");

    chk_port0_write: assert property (wrPort0 |=>
        portZeroEnable == $past(avmmReq.writedata[EN_W-1:0]))
        else $error("port zero enable did not take the written value");

    chk_port1_write: assert property (wrPort1 |=>
        portOneEnable == $past(avmmReq.writedata[EN_W-1:0]))
        else $error("port one enable did not take the written value");

    chk_pin_three_route: assert property (clkEn |=>
        gpioThreeOe == $past(route_q[ROUTE_GP3_BIT])
        && gpioThreeOut == ($past(route_q[ROUTE_GP3_BIT]) && $past(linkGood_q)))
        else $error("pin three routing mismatch");

    chk_pin_zero_route: assert property (wrRoute ##1 clkEn |=>
        gpioZeroOe == $past(avmmReq.writedata[ROUTE_GP0_BIT], 2))
        else $error("pin zero enable does not follow routing bit");

    chk_link_status_read: assert property (
        (!avmmRsp.waitrequest && avmmReq.read && avmmReq.address == byteAddr(IDX_ROUTE))
        |-> avmmRsp.readdata[STATUS_BIT] == $past(linkGood_q))
        else $error("status bit does not show link-good level");

    chk_vc_write: assert property (wrVc |=>
        virtualChannel == $past(avmmReq.writedata[VC_LSB+VC_W-1:VC_LSB]))
        else $error("virtual channel did not take the written code");

    chk_unmapped_ignored: assert property (
        (acceptWr && avmmReq.address == 8'hFC) |=> $stable(port0_q) && $stable(vc_q))
        else $error("write to unmapped word changed a register");

    // Register reset values, updates, holds and reads
    chk_route_reset_vals: assert property ($rose(rst_n) |->
        route_q[ROUTE_GP0_BIT] && !route_q[ROUTE_GP3_BIT] && !linkGood_q)
        else $error("routing bits or status wrong after reset");

    chk_route_write: assert property (wrRoute |=>
        route_q == $past(avmmReq.writedata[7:1]))
        else $error("routing bits did not take the written value");

    chk_port_hold: assert property ((rst_n && !wrPort0 && !wrPort1) |=>
        $stable(portZeroEnable) && $stable(portOneEnable))
        else $error("port enable changed without a write");

    chk_vc_hold: assert property ((rst_n && !wrVc) |=> $stable(virtualChannel))
        else $error("virtual channel changed without a write");

    chk_read_port0: assert property (
        (!avmmRsp.waitrequest && avmmReq.read && avmmReq.address == byteAddr(IDX_PORT0))
        |-> avmmRsp.readdata[EN_W-1:0] == $past(portZeroEnable))
        else $error("port zero read does not show the enable field");

    // Routing, link capture and pins
    chk_link_capture: assert property ((rst_n && clkEn) |=> linkGood_q == $past(linkGood))
        else $error("link-good level not captured");

    chk_pin_zero_out: assert property ((rst_n && clkEn) |=>
        gpioZeroOut == ($past(route_q[ROUTE_GP0_BIT]) && $past(linkGood_q)))
        else $error("pin zero level does not follow link-good");

    // Bus handshake and interrupts
    chk_wait_one_low: assert property ((clkEn && !avmmRsp.waitrequest) |=> avmmRsp.waitrequest)
        else $error("waitrequest stayed low beyond one cycle");

    chk_upper_read_zero: assert property ((!avmmRsp.waitrequest && avmmReq.read) |->
        avmmRsp.readdata[DATA_W-1:8] == '0)
        else $error("upper read bits not zero");

    chk_event_sets_status: assert property ((rst_n && clkEn && |events) |=>
        (irqStatus & $past(events)) == $past(events))
        else $error("link-good edge did not set its status bit");

    chk_clear_status: assert property (wrIrqClr |=>
        (irqStatus & $past(avmmReq.writedata[IRQ_W-1:0]) & ~$past(events)) == '0)
        else $error("written one did not clear its status bit");

    chk_mask_write: assert property (wrIrqMask |=> irqMask == $past(avmmReq.writedata[IRQ_W-1:0]))
        else $error("interrupt mask did not take the written value");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_port1_enabled: cover property (wrPort1 ##1 portOneEnable == EN_ALL);
    cov_vc_three: cover property (virtualChannel == 2'b11);
    cov_link_irq: cover property (events[IRQ_RISE_BIT] ##[1:3] irq);
    cov_pin_three: cover property (gpioThreeOe && gpioThreeOut);

endmodule // csi2_output_config

/* File: verif/csi2_rx_model.sv */
/*
 * Host-side CSI-2 receiver and GPIO pads as the host sees them.
 * Assumes the bank's outputs are synchronous to clk_sys.
 */
module csi2_rx_model
    import csi2_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [EN_W-1:0] portZeroEnable,
    input wire logic [EN_W-1:0] portOneEnable,
    input wire logic [VC_W-1:0] virtualChannel,
    input wire logic gpioZeroOut,
    input wire logic gpioZeroOe,
    input wire logic gpioThreeOut,
    input wire logic gpioThreeOe,
    output logic laneZeroOn,
    output logic laneOneOn,
    output logic [VC_W-1:0] vcSeen,
    output logic pinZero,
    output logic pinThree
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pads
    // ------------------------------------------------------------
    // Pads carry pull-downs, so a released pin reads low
    assign pinZero = gpioZeroOe ? gpioZeroOut : 1'b0;
    assign pinThree = gpioThreeOe ? gpioThreeOut : 1'b0;

    // ------------------------------------------------------------
    // Receiver state
    // ------------------------------------------------------------
    // A port streams only with its whole field set; partial codes count as off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            laneZeroOn <= 1'b0;
            laneOneOn <= 1'b0;
            vcSeen <= 2'h0;
        end else begin
            laneZeroOn <= (portZeroEnable == EN_ALL);
            laneOneOn <= (portOneEnable == EN_ALL);
            vcSeen <= virtualChannel;
        end
    end
endmodule // csi2_rx_model

/* File: verif/tb.sv */
/*
 * Self-checking bench for the CSI-2 output configuration bank.
 * Assumes a synchronous link-good input; every access waits on waitrequest.
 */
module tb
    import csi2_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PWRUP_WAIT = 40000;
    logic clk_sys;
    logic rst_n;
    logic linkGood;
    avmm_req_t avmmReq;
    avmm_rsp_t avmmRsp;
    logic [EN_W-1:0] portZeroEnable;
    logic [EN_W-1:0] portOneEnable;
    logic [VC_W-1:0] virtualChannel;
    logic [VC_W-1:0] vcSeen;
    logic gpioZeroOut, gpioZeroOe, gpioThreeOut, gpioThreeOe;
    logic irq, laneZeroOn, laneOneOn, pinZero, pinThree;
    logic [DATA_W-1:0] rd;
    int failures;
    int compares;

    csi2_output_config i_csi2_output_config (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1),
        .avmmReq(avmmReq), .avmmRsp(avmmRsp), .linkGood(linkGood), .portZeroEnable(portZeroEnable),
        .portOneEnable(portOneEnable), .virtualChannel(virtualChannel), .gpioZeroOut(gpioZeroOut),
        .gpioZeroOe(gpioZeroOe), .gpioThreeOut(gpioThreeOut), .gpioThreeOe(gpioThreeOe), .irq(irq));

    csi2_rx_model i_csi2_rx_model (.clk_sys(clk_sys), .rst_n(rst_n), .portZeroEnable(portZeroEnable),
        .portOneEnable(portOneEnable), .virtualChannel(virtualChannel), .gpioZeroOut(gpioZeroOut),
        .gpioZeroOe(gpioZeroOe), .gpioThreeOut(gpioThreeOut), .gpioThreeOe(gpioThreeOe),
        .laneZeroOn(laneZeroOn), .laneOneOn(laneOneOn), .vcSeen(vcSeen), .pinZero(pinZero),
        .pinThree(pinThree));

    // ------------------------------------------------------------
    // Clock and helpers
    // ------------------------------------------------------------
    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Print the counts and the verdict, then stop
    task automatic final_report();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare one value
    task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access: raise after an edge, hold until waitrequest is sampled low, then release
    task automatic bus(input logic wr, input logic [3:0] be, input logic [IDX_W-1:0] idx,
                       input logic [7:0] d, output logic [DATA_W-1:0] q);
        int n;
        @(posedge clk_sys);
        avmmReq.read <= ~wr;
        avmmReq.write <= wr;
        avmmReq.address <= {idx, 2'b00};
        avmmReq.byteenable <= be;
        avmmReq.writedata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                failures++;
                $display("Error waitrequest expected 0 seen 1");
                final_report();
            end
        end while (avmmRsp.waitrequest !== 1'b0);
        q = avmmRsp.readdata;
        avmmReq.read <= 1'b0;
        avmmReq.write <= 1'b0;
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic [DATA_W-1:0] q;
        bus(1'b1, 4'h1, idx, d, q);
    endtask

    task automatic rdchk(input string what, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        bus(1'b0, 4'h1, idx, 8'h00, q);
        check(what, exp, q);
    endtask

    // Let register, pin and receiver updates land
    task automatic settle();
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic setLink(input logic v);
        @(posedge clk_sys);
        linkGood <= v;
        settle();
    endtask

    // Controller-driven release, then the power-up wait before any access
    task automatic doReset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (PWRUP_WAIT) @(posedge clk_sys);
    endtask

    // Write an enable field and check register, output and receiver
    task automatic enStep(input logic [IDX_W-1:0] idx, input logic [7:0] v);
        wr(idx, v);
        settle();
        rdchk("enable reg", idx, {24'h00_0000, v});
        check("enable out", v[5:0], idx == IDX_PORT0 ? portZeroEnable : portOneEnable);
        check("lane state", v[5:0] == EN_ALL, idx == IDX_PORT0 ? laneZeroOn : laneOneOn);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        compares = 0;
        rst_n = 1'b0;
        linkGood = 1'b0;
        avmmReq = '0;
        doReset();
        rdchk("port zero reg", IDX_PORT0, 32'h0000_003F);
        rdchk("port one reg", IDX_PORT1, 32'h0000_0000);
        rdchk("routing reg", IDX_ROUTE, 32'h0000_0002);
        rdchk("channel reg", IDX_VC, 32'h0000_0000);
        rdchk("unmapped read", 6'h00, 32'h0000_0000);
        check("pin zero", 1'b0, pinZero);
        check("pin three oe", 1'b0, gpioThreeOe);
        $display("Test reset values done");
        enStep(IDX_PORT0, 8'h00);
        enStep(IDX_PORT0, 8'h3F);
        enStep(IDX_PORT1, 8'h3F);
        enStep(IDX_PORT1, 8'h00);
        bus(1'b1, 4'h0, IDX_PORT1, 8'h3F, rd);
        settle();
        rdchk("masked write", IDX_PORT1, 32'h0000_0000);
        check("port one out", 6'h00, portOneEnable);
        $display("Test port enables done");
        for (int c = 0; c < 4; c++) begin
            wr(IDX_VC, {c[1:0], 6'h00});
            settle();
            check("virtual channel", c[1:0], virtualChannel);
            check("channel seen", c[1:0], vcSeen);
        end
        rdchk("channel reg", IDX_VC, 32'h0000_00C0);
        $display("Test virtual channel done");
        setLink(1'b1);
        rdchk("routing link up", IDX_ROUTE, 32'h0000_0003);
        check("pin zero", 1'b1, pinZero);
        check("pin three", 1'b0, pinThree);
        wr(IDX_ROUTE, 8'h04);
        settle();
        rdchk("routing to three", IDX_ROUTE, 32'h0000_0005);
        check("pin zero oe", 1'b0, gpioZeroOe);
        check("pin three", 1'b1, pinThree);
        setLink(1'b0);
        rdchk("routing link down", IDX_ROUTE, 32'h0000_0004);
        check("pin three", 1'b0, pinThree);
        $display("Test link routing done");
        rdchk("irq status", IDX_IRQ_STAT, 32'h0000_0003);
        check("irq masked", 1'b0, irq);
        wr(IDX_IRQ_MASK, 8'h02);
        settle();
        check("irq raised", 1'b1, irq);
        wr(IDX_IRQ_STAT, 8'h01);
        settle();
        rdchk("irq status", IDX_IRQ_STAT, 32'h0000_0002);
        check("irq held", 1'b1, irq);
        wr(IDX_IRQ_STAT, 8'h02);
        settle();
        rdchk("irq status", IDX_IRQ_STAT, 32'h0000_0000);
        rdchk("irq mask", IDX_IRQ_MASK, 32'h0000_0002);
        check("irq cleared", 1'b0, irq);
        $display("Test interrupts done");
        wr(IDX_PORT1, 8'h3F);
        wr(IDX_VC, 8'h80);
        setLink(1'b1);
        doReset();
        rdchk("port zero reg", IDX_PORT0, 32'h0000_003F);
        rdchk("port one reg", IDX_PORT1, 32'h0000_0000);
        rdchk("channel reg", IDX_VC, 32'h0000_0000);
        rdchk("routing reg", IDX_ROUTE, 32'h0000_0003);
        check("pin zero", 1'b1, pinZero);
        check("pin three", 1'b0, pinThree);
        check("lane one", 1'b0, laneOneOn);
        $display("Test restart done");
        final_report();
    end
endmodule // tb
